// ### iorl_pkg.sv
// package for the port reset / low-power pin control block
// assumes a 32-bit axi4-lite register bus and 8-bit byte addressing
package iorl_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_DRIVE_MODE = 8'h00;
    localparam logic [7:0] OFF_OUT_DATA   = 8'h04;
    localparam logic [7:0] OFF_PIN_STATE  = 8'h08;
    localparam logic [7:0] OFF_IRQ_CFG    = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STAT   = 8'h10;
    localparam logic [7:0] OFF_RST_CFG    = 8'h14;
    localparam logic [7:0] OFF_CTRL       = 8'h18;

    // field positions
    localparam int RST_CFG_LOADED_BIT = 8;
    localparam int CTRL_I2C_WAKE_BIT  = 0;

    // three-bit drive mode encodings
    localparam logic [2:0] DM_HIZ_ANALOG  = 3'h0;
    localparam logic [2:0] DM_HIZ_DIGITAL = 3'h1;
    localparam logic [2:0] DM_RES_UP      = 3'h2;
    localparam logic [2:0] DM_RES_DOWN    = 3'h3;
    localparam logic [2:0] DM_OD_LOW      = 3'h4;
    localparam logic [2:0] DM_OD_HIGH     = 3'h5;
    localparam logic [2:0] DM_STRONG      = 3'h6;
    localparam logic [2:0] DM_RES_UPDOWN  = 3'h7;

    // per-pin edge selection
    localparam logic [1:0] IRQ_NONE = 2'h0;
    localparam logic [1:0] IRQ_RISE = 2'h1;
    localparam logic [1:0] IRQ_FALL = 2'h2;
    localparam logic [1:0] IRQ_BOTH = 2'h3;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // latched write request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } iorl_wr_t;

    // bring-up sequence
    typedef enum logic [1:0] {ST_HOLD, ST_LOAD, ST_RUN} iorl_state_t;

endpackage

// ### iorl_port.sv
// one i/o port: drive modes, reset pull load, pin events, scan chain
// assumes pad inputs synchronous to aclk and tap state strobes from
// an external test controller, also synchronous to aclk
`timescale 1ns/1ns
module iorl_port
    import iorl_pkg::*;
#(
    parameter int         N           = 8,
    parameter logic       I2C_WAKE_OK = 1'b0,
    parameter logic [N-1:0] TOLERANT  = '0
)(
    input  wire logic            aclk,
    input  wire logic            aresetn,
    input  wire logic [7:0]      s_axi_awaddr,
    input  wire logic            s_axi_awvalid,
    output logic                 s_axi_awready,
    input  wire logic [31:0]     s_axi_wdata,
    input  wire logic [3:0]      s_axi_wstrb,
    input  wire logic            s_axi_wvalid,
    output logic                 s_axi_wready,
    output logic [1:0]           s_axi_bresp,
    output logic                 s_axi_bvalid,
    input  wire logic            s_axi_bready,
    input  wire logic [7:0]      s_axi_araddr,
    input  wire logic            s_axi_arvalid,
    output logic                 s_axi_arready,
    output logic [31:0]          s_axi_rdata,
    output logic [1:0]           s_axi_rresp,
    output logic                 s_axi_rvalid,
    input  wire logic            s_axi_rready,
    input  wire logic            nv_reset_pull,
    input  wire logic            lp_mode,
    input  wire logic            i2c_addr_match,
    input  wire logic [N-1:0]    pad_in,
    output logic [3*N-1:0]       pad_mode,
    output logic [N-1:0]         pad_out,
    output logic [N-1:0]         pad_oe,
    output logic                 irq_req,
    output logic                 wake,
    input  wire logic            bs_capture,
    input  wire logic            bs_shift,
    input  wire logic            bs_update,
    input  wire logic            bs_extest,
    input  wire logic            bs_tdi,
    output logic                 bs_tdo
);

    iorl_state_t     st_ff;
    iorl_wr_t        wr_ff;
    logic            aw_got_ff, w_got_ff, i2c_wake_en_ff, rst_pull_ff;
    logic [3*N-1:0]  dm_ff, pad_mode_ff;
    logic [N-1:0]    out_ff, prev_ff, stat_ff, evt, pad_out_ff, pad_oe_ff;
    logic [2*N-1:0]  icfg_ff, bsr_ff, bsu_ff;
    logic            awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0]      bresp_ff, rresp_ff;
    logic [31:0]     rdata_ff, rd_word;
    logic            rd_ok, wr_fire, irq_ff, wake_ff;

    // byte-lane merge of a write into an existing word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input iorl_wr_t w);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
            if (w.strb[b]) r[8*b +: 8] = w.data[8*b +: 8];
        return r;
    endfunction

    // output enable implied by a drive mode and data bit
    function automatic logic mode_oe(input logic [2:0] m, input logic d);
        case (m)
            DM_STRONG:  return 1'b1;
            DM_OD_LOW:  return ~d;
            DM_OD_HIGH: return d;
            default:    return 1'b0; // resistive modes drive via pad
        endcase
    endfunction

    // bring-up: hold (nonvolatile pull captured on release), load it, then run
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_ff <= ST_HOLD;
        else if (st_ff == ST_HOLD)
            st_ff <= ST_LOAD;
        else
            st_ff <= ST_RUN;
    end

    // capture strap after release, never under reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rst_pull_ff <= 1'b0;
        else if (st_ff == ST_HOLD)
            rst_pull_ff <= nv_reset_pull;
    end

    // axi write channel: address and data taken in either order
    assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_ff  <= 1'b0;
            w_got_ff   <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
            wr_ff      <= '0;
        end
        else
        begin
            if (s_axi_awvalid && awready_ff)
            begin
                aw_got_ff  <= 1'b1;
                wr_ff.addr <= s_axi_awaddr;
                awready_ff <= 1'b0;
            end
            else if (!aw_got_ff && !bvalid_ff)
                awready_ff <= 1'b1;
            if (s_axi_wvalid && wready_ff)
            begin
                w_got_ff   <= 1'b1;
                wr_ff.data <= s_axi_wdata;
                wr_ff.strb <= s_axi_wstrb;
                wready_ff  <= 1'b0;
            end
            else if (!w_got_ff && !bvalid_ff)
                wready_ff <= 1'b1;
            if (wr_fire)
            begin
                aw_got_ff <= 1'b0;
                w_got_ff  <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff  <= (wr_ff.addr > OFF_CTRL || wr_ff.addr[1:0] != 2'h0)
                             ? RESP_SLVERR : RESP_OKAY;
            end
            else if (bvalid_ff && s_axi_bready)
                bvalid_ff <= 1'b0;
        end
    end

    // software-owned configuration; reset load overrides drive modes
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dm_ff          <= '0;
            out_ff         <= '0;
            icfg_ff        <= '0;
            i2c_wake_en_ff <= 1'b0;
        end
        else if (st_ff == ST_LOAD)
            dm_ff <= {N{rst_pull_ff ? DM_RES_UP : DM_RES_DOWN}};
        else if (wr_fire)
        begin
            // only bus writes and the reset load change these, so sleep keeps them
            case (wr_ff.addr)
                OFF_DRIVE_MODE: dm_ff <=
                    (3*N)'(merge(32'(dm_ff), wr_ff));
                OFF_OUT_DATA:   out_ff <= N'(merge(32'(out_ff), wr_ff));
                OFF_IRQ_CFG:    icfg_ff <=
                    (2*N)'(merge(32'(icfg_ff), wr_ff));
                // only the lane that holds the enable may change it
                OFF_CTRL:
                    if (wr_ff.strb[CTRL_I2C_WAKE_BIT / 8])
                        i2c_wake_en_ff <= wr_ff.data[CTRL_I2C_WAKE_BIT];
                default: ;
            endcase
        end
    end

    // edge detect per pin; runs regardless of low-power mode
    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            case (icfg_ff[2*i +: 2])
                IRQ_RISE: evt[i] = pad_in[i] && !prev_ff[i];
                IRQ_FALL: evt[i] = !pad_in[i] && prev_ff[i];
                IRQ_BOTH: evt[i] = pad_in[i] ^ prev_ff[i];
                default:  evt[i] = 1'b0;
            endcase
        end
    end

    // sticky status, write one to clear, a new event beats the clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            prev_ff <= '0;
            stat_ff <= '0;
            irq_ff  <= 1'b0;
            wake_ff <= 1'b0;
        end
        else
        begin
            prev_ff <= pad_in;
            if (wr_fire && wr_ff.addr == OFF_IRQ_STAT)
                stat_ff <= (stat_ff & ~N'(merge(32'h0, wr_ff))) | evt;
            else
                stat_ff <= stat_ff | evt;
            irq_ff <= |stat_ff;
            // i2c match only wakes when these pins are the dedicated ones
            wake_ff <= lp_mode && (|stat_ff || (i2c_wake_en_ff &&
                       I2C_WAKE_OK && i2c_addr_match));
        end
    end

    // boundary scan: low half pin values, high half enables
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bsr_ff <= '0;
            bsu_ff <= '0;
        end
        else
        begin
            if (bs_capture)
                bsr_ff <= {pad_oe_ff, pad_in};
            else if (bs_shift)
                bsr_ff <= {bs_tdi, bsr_ff[2*N-1:1]};
            if (bs_update)
                bsu_ff <= bsr_ff;
        end
    end

    // pad drive; analog hi-z until the pull load is done
    always_ff @(posedge aclk)
    begin
        if (!aresetn || st_ff != ST_RUN)
        begin
            pad_mode_ff <= '0;
            pad_out_ff  <= '0;
            pad_oe_ff   <= '0;
        end
        else if (bs_extest)
        begin
            // scan owns the pins during board test
            pad_mode_ff <= {N{DM_STRONG}};
            pad_out_ff  <= bsu_ff[N-1:0];
            pad_oe_ff   <= bsu_ff[2*N-1:N];
        end
        else
        begin
            pad_mode_ff <= dm_ff;
            pad_out_ff  <= out_ff;
            for (int i = 0; i < N; i++)
                pad_oe_ff[i] <= mode_oe(dm_ff[3*i +: 3], out_ff[i]);
        end
    end

    // read decode; unmapped or misaligned answers slverr
    always_comb
    begin
        rd_word = 32'h0;
        rd_ok   = s_axi_araddr[1:0] == 2'h0;
        case (s_axi_araddr)
            OFF_DRIVE_MODE: rd_word = 32'(dm_ff);
            OFF_OUT_DATA:   rd_word = 32'(out_ff);
            OFF_PIN_STATE:  rd_word = 32'(pad_in);
            OFF_IRQ_CFG:    rd_word = 32'(icfg_ff);
            OFF_IRQ_STAT:   rd_word = 32'(stat_ff);
            OFF_RST_CFG:    rd_word = 32'({st_ff == ST_RUN, 7'h0,
                                           rst_pull_ff});
            OFF_CTRL:       rd_word = 32'({TOLERANT, 7'h0, i2c_wake_en_ff});
            default:        rd_ok = 1'b0;
        endcase
    end

    // axi read channel, one outstanding read
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= '0;
            rresp_ff   <= RESP_OKAY;
        end
        else if (s_axi_arvalid && arready_ff)
        begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= rd_word;
            rresp_ff   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_ff && s_axi_rready)
            rvalid_ff <= 1'b0;
        else if (!rvalid_ff)
            arready_ff <= 1'b1;
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign pad_mode      = pad_mode_ff;
    assign pad_out       = pad_out_ff;
    assign pad_oe        = pad_oe_ff;
    assign irq_req       = irq_ff;
    assign wake          = wake_ff;
    assign bs_tdo        = bsr_ff[0];

    // checks
    a_hiz_in_reset: assert property (@(posedge aclk)
        !aresetn |=> pad_mode_ff == '0 && pad_oe_ff == '0)
        else $error("pins not analog hi-z in reset");
    a_nv_capture: assert property (
        @(posedge aclk) disable iff (!aresetn)
        st_ff == ST_HOLD |=> rst_pull_ff == $past(nv_reset_pull))
        else $error("reset pull not captured at release");
    a_pull_applied: assert property (
        @(posedge aclk) disable iff (!aresetn)
        st_ff == ST_LOAD |=> ##1 pad_mode_ff[2:0] ==
        ($past(rst_pull_ff, 2) ? DM_RES_UP : DM_RES_DOWN)
        || $past(bs_extest))
        else $error("loaded pull not on pins");
    a_sleep_retain: assert property (
        @(posedge aclk) disable iff (!aresetn)
        lp_mode && !wr_fire && st_ff == ST_RUN
        |=> $stable(dm_ff) && $stable(out_ff))
        else $error("pin state changed in low power");
    a_sleep_wake: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (lp_mode && evt != '0) ##1 lp_mode |=> wake_ff)
        else $error("pin event did not wake");
    a_scan_capture: assert property (
        @(posedge aclk) disable iff (!aresetn)
        bs_capture |=> bsr_ff[N-1:0] == $past(pad_in))
        else $error("scan capture wrong");
    // on plain pins a match alone must not wake, only pin events may
    a_i2c_wake: assert property (
        @(posedge aclk) disable iff (!aresetn)
        lp_mode && i2c_addr_match && i2c_wake_en_ff
        |=> wake_ff == (I2C_WAKE_OK || irq_ff))
        else $error("i2c match wake wrong");
    a_mode_follows: assert property (
        @(posedge aclk) disable iff (!aresetn)
        st_ff == ST_RUN && !bs_extest |=> pad_mode_ff == $past(dm_ff))
        else $error("pad mode not from field");
    a_event_sets: assert property (
        @(posedge aclk) disable iff (!aresetn)
        evt != '0 |=> (stat_ff & $past(evt)) == $past(evt)
        ##1 irq_ff)
        else $error("event lost or no request");
    a_hiz_till_load: assert property (@(posedge aclk)
        st_ff != ST_RUN |=> pad_oe_ff == '0 && pad_mode_ff == '0)
        else $error("pins driven before load");
    c_bringup: cover property (@(posedge aclk)
        st_ff == ST_LOAD ##1 st_ff == ST_RUN);
    c_wake: cover property (@(posedge aclk) lp_mode ##1 wake_ff);
    c_extest: cover property (@(posedge aclk) bs_update ##1 bs_extest);
    c_write: cover property (@(posedge aclk) wr_fire ##1 s_axi_bready);

endmodule

// ### iorl_port_test.sv
// self-checking bench for the port reset / low-power pin control block
// assumes iorl_pkg and iorl_port are compiled first, default parameters
`timescale 1ns/1ns
module iorl_port_test import iorl_pkg::*;;

    typedef struct packed {
        logic [2:0] code;
        logic [7:0] oe;
    } iorl_row_t;

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, nv_reset_pull = 1'b1;
    logic        lp_mode = 1'b0, i2c_addr_match = 1'b0;
    logic [7:0]  pad_in = 8'h00;
    logic        bs_capture = 1'b0, bs_shift = 1'b0, bs_update = 1'b0;
    logic        bs_extest = 1'b0, bs_tdi = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, irq_req, wake, bs_tdo;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rdat;
    logic [23:0] pad_mode;
    logic [7:0]  pad_out, pad_oe, exp;
    logic [15:0] pat = 16'h0f96;
    int          miscompares = 0, compares = 0;
    // drive code beside the enable it gives with output data 0xa5
    iorl_row_t   rows [8] = '{'{DM_HIZ_ANALOG, 8'h00},
        '{DM_HIZ_DIGITAL, 8'h00}, '{DM_RES_UP, 8'h00},
        '{DM_RES_DOWN, 8'h00}, '{DM_OD_LOW, 8'h5a}, '{DM_OD_HIGH, 8'ha5},
        '{DM_STRONG, 8'hff}, '{DM_RES_UPDOWN, 8'h00}};

    iorl_port iorl_port_i (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .nv_reset_pull, .lp_mode,
        .i2c_addr_match, .pad_in, .pad_mode, .pad_out, .pad_oe, .irq_req,
        .wake, .bs_capture, .bs_shift, .bs_update, .bs_extest, .bs_tdi,
        .bs_tdo
    );

    // 25 mhz clock
    always #20 aclk = ~aclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        compares++;
        if (got !== want)
        begin
            miscompares++;
            $display("MISMATCH at %0t: got %h want %h", $time, got, want);
        end
    endtask

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            aw_ok = aw_ok | s_axi_awready;
            w_ok = w_ok | s_axi_wready;
            s_axi_awvalid <= !aw_ok;
            s_axi_wvalid <= !w_ok;
        end
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // pads must stay analog hi-z until the pull load has landed
    task automatic do_reset(input logic pull, input logic [2:0] code);
        @(posedge aclk);
        aresetn <= 1'b0;
        nv_reset_pull <= pull;
        repeat (20) @(posedge aclk);
        #1;
        chk({pad_oe, pad_mode}, 32'h0);
        @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        #1;
        chk(pad_mode, 32'h0);
        @(posedge aclk);
        #1;
        chk(pad_mode, {8'h00, {8{code}}});
        rd(OFF_RST_CFG);
        chk(rdat, {23'h0, 1'b1, 7'h0, pull});
    endtask

    task automatic close_out();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // whole run is a few hundred cycles, so this only cuts a hang
    initial
    begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        close_out();
    end

    initial
    begin
        do_reset(1'b1, DM_RES_UP);
        // every drive code on all pins at once
        wr(OFF_OUT_DATA, 32'ha5);
        foreach (rows[i])
        begin
            wr(OFF_DRIVE_MODE, {8'h00, {8{rows[i].code}}});
            repeat (2) @(posedge aclk);
            #1;
            chk(pad_mode, {8'h00, {8{rows[i].code}}});
            chk(pad_oe, rows[i].oe);
            rd(OFF_DRIVE_MODE);
            chk(rdat, {8'h00, {8{rows[i].code}}});
        end
        // unmapped and misaligned places refuse; read-only config holds
        rd(8'h1c);
        chk({resp, rdat[29:0]}, {RESP_SLVERR, 30'h0});
        wr(8'h02, 32'hffff_ffff);
        chk(resp, RESP_SLVERR);
        wr(OFF_RST_CFG, 32'h0);
        rd(OFF_RST_CFG);
        chk(rdat, 32'h101);
        // each edge selection, rise then fall
        for (int m = 0; m < 4; m++)
        begin
            wr(OFF_IRQ_CFG, {16'h0, {8{m[1:0]}}});
            wr(OFF_IRQ_STAT, 32'hff);
            @(posedge aclk);
            pad_in <= 8'hff;
            repeat (4) @(posedge aclk);
            #1;
            exp = m[0] ? 8'hff : 8'h00;
            chk(irq_req, |exp);
            rd(OFF_IRQ_STAT);
            chk(rdat, exp);
            @(posedge aclk);
            pad_in <= 8'h00;
            repeat (4) @(posedge aclk);
            rd(OFF_IRQ_STAT);
            chk(rdat, m[1] ? 8'hff : exp);
        end
        wr(OFF_IRQ_STAT, 32'hff);
        repeat (2) @(posedge aclk);
        #1;
        chk(irq_req, 1'b0);
        // sleep: pins frozen, events still wake; i2c match on plain pins
        wr(OFF_DRIVE_MODE, {8'h00, {8{DM_STRONG}}});
        wr(OFF_OUT_DATA, 32'h5a);
        wr(OFF_IRQ_CFG, 32'hffff);
        wr(OFF_CTRL, 32'h1);
        // no tolerant pins in this build, so any drive code may be used
        rd(OFF_CTRL);
        chk(rdat, 32'h1);
        @(posedge aclk);
        lp_mode <= 1'b1;
        i2c_addr_match <= 1'b1;
        repeat (4) @(posedge aclk);
        #1;
        chk(wake, 1'b0);
        @(posedge aclk);
        pad_in <= 8'h81;
        repeat (4) @(posedge aclk);
        #1;
        chk({wake, irq_req}, 32'h3);
        chk({pad_mode, pad_oe}, {{8{DM_STRONG}}, 8'hff});
        chk(pad_out, 32'h5a);
        @(posedge aclk);
        lp_mode <= 1'b0;
        i2c_addr_match <= 1'b0;
        // scan: capture then update, then shift a pattern in
        wr(OFF_DRIVE_MODE, 32'h0);
        @(posedge aclk);
        bs_capture <= 1'b1;
        @(posedge aclk);
        bs_capture <= 1'b0;
        bs_update <= 1'b1;
        @(posedge aclk);
        bs_update <= 1'b0;
        bs_extest <= 1'b1;
        repeat (2) @(posedge aclk);
        #1;
        chk({pad_oe, pad_out}, 32'h0081);
        chk(bs_tdo, 1'b1);
        for (int b = 0; b < 16; b++)
        begin
            @(posedge aclk);
            bs_shift <= 1'b1;
            bs_tdi <= pat[b];
        end
        @(posedge aclk);
        bs_shift <= 1'b0;
        bs_update <= 1'b1;
        @(posedge aclk);
        bs_update <= 1'b0;
        repeat (2) @(posedge aclk);
        #1;
        chk({pad_oe, pad_out}, pat);
        chk(pad_mode, {8'h00, {8{DM_STRONG}}});
        chk(bs_tdo, pat[0]);
        @(posedge aclk);
        bs_extest <= 1'b0;
        // second reset from driven pins, pull-down this time
        wr(OFF_DRIVE_MODE, {8'h00, {8{DM_STRONG}}});
        do_reset(1'b0, DM_RES_DOWN);
        close_out();
    end

endmodule
